/* File: pcg_defs.svh */
`ifndef PCG_DEFS_SVH
`define PCG_DEFS_SVH

`define PCG_RAILS          8
`define PCG_GPOS           4

// register byte offsets
`define PCG_OFF_GRP1       8'h00
`define PCG_OFF_GRP2       8'h04
`define PCG_OFF_SLP_GRP    8'h08
`define PCG_OFF_CTRL       8'h0c
`define PCG_OFF_GPO_CFG    8'h10
`define PCG_OFF_GPO_VAL    8'h14
`define PCG_OFF_PG_SEL0    8'h18
`define PCG_OFF_STATUS     8'h28
`define PCG_OFF_IRQ_STAT   8'h2c
`define PCG_OFF_IRQ_MASK   8'h30
`define PCG_VOUT_REGION    2'h1

// field positions
`define PCG_CTRL_SLEEP_BIT 0
`define PCG_CFG_OD_LSB     4
`define PCG_IRQ_IN1        0
`define PCG_IRQ_IN2        1
`define PCG_IRQ_PG_LOST    2
`define PCG_IRQ_SLEEP      3
`define PCG_IRQ_BITS       4

// reset values
`define PCG_GRP1_RST       8'h00
`define PCG_GRP2_RST       8'h00
`define PCG_SLP_GRP_RST    8'h00
`define PCG_PG_SEL_RST     8'h00
`define PCG_VOUT_NRM_RST   8'h40
`define PCG_VOUT_SLP_RST   8'h30

// bus answers
`define PCG_RESP_OKAY      2'h0
`define PCG_RESP_SLVERR    2'h2

`endif

/* File: pcg_pkg.sv */
package pcg_pkg;

  typedef logic [7:0] pcg_rail_t;

  typedef enum logic {
    PCG_SRC_PGOOD = 1'b0,
    PCG_SRC_REG   = 1'b1
  } pcg_gpo_src_e;

  function automatic logic pcg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  // an empty selection reads as good
  function automatic logic pcg_group_good(input pcg_rail_t pg, input pcg_rail_t sel);
    return &(pg | ~sel);
  endfunction

endpackage

/* File: pcg_in_sync.sv */
`timescale 1ns/1ps
module pcg_in_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  // pins
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_stable
);

  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  wire  [WIDTH-1:0] agree = ~(s2 ^ s3);

  // a bit moves only once the last two stages agree, which drops one-cycle glitches
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      s1       <= '0;
      s2       <= '0;
      s3       <= '0;
      o_stable <= '0;
    end else begin
      s1       <= i_async;
      s2       <= s1;
      s3       <= s2;
      o_stable <= (agree & s3) | (~agree & o_stable);
    end
  end

endmodule

/* File: pcg_gpo_drive.sv */
`timescale 1ns/1ps
module pcg_gpo_drive
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  // configuration
  input  wire pcg_gpo_src_e i_src,
  input  wire logic         i_reg_val,
  input  wire pcg_rail_t    i_sel,
  input  wire logic         i_open_drain,
  // rail status
  input  wire pcg_rail_t    i_pgood,
  // pin
  output logic              o_pin_o,
  output logic              o_pin_oe
);

  wire level = (i_src == PCG_SRC_REG) ? i_reg_val : pcg_group_good(i_pgood, i_sel);

  // open-drain pulls low only; the high level comes from the board pull-up
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_pin_o  <= 1'b0;
      o_pin_oe <= 1'b0;
    end else if (i_open_drain) begin
      o_pin_o  <= 1'b0;
      o_pin_oe <= ~level;
    end else begin
      o_pin_o  <= level;
      o_pin_oe <= 1'b1;
    end
  end

endmodule

/* File: pcg_top.sv */
`timescale 1ns/1ps
`include "pcg_defs.svh"
module pcg_top
  import pcg_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  // register bus
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [31:0] i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  // control pins
  input  wire logic        i_rail_group_enable_in_1,
  input  wire logic        i_enable_or_sleep_request_in_2,
  // rail side
  input  wire pcg_rail_t   i_rail_pgood,
  output pcg_rail_t        o_rail_enable,
  output pcg_rail_t        o_rail_sleep,
  output logic [63:0]      o_rail_vout_code,
  // interrupt pin
  output logic             o_interrupt_out_n_o,
  output logic             o_interrupt_out_n_oe,
  // general outputs
  output logic             o_general_out_1_o,
  output logic             o_general_out_1_oe,
  output logic             o_general_out_2_o,
  output logic             o_general_out_2_oe,
  output logic             o_general_out_3_o,
  output logic             o_general_out_3_oe,
  output logic             o_general_out_4_opendrain_o,
  output logic             o_general_out_4_opendrain_oe
);

  logic [1:0] pin_s;
  pcg_rail_t  pg_s;

  pcg_in_sync #(.WIDTH(2)) u_pin_sync (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_async  ({i_enable_or_sleep_request_in_2, i_rail_group_enable_in_1}),
    .o_stable (pin_s)
  );

  pcg_in_sync #(.WIDTH(8)) u_pg_sync (
    .i_clk    (i_clk),
    .i_rstn   (i_rstn),
    .i_async  (i_rail_pgood),
    .o_stable (pg_s)
  );

  // software state
  pcg_rail_t grp1;
  pcg_rail_t grp2;
  pcg_rail_t slp_grp;
  logic      sleep_mode;
  logic [3:0] gpo_src;
  logic [2:0] gpo_od;
  logic [3:0] gpo_val;
  pcg_rail_t pg_sel [`PCG_GPOS];
  pcg_rail_t vout_nrm [`PCG_RAILS];
  pcg_rail_t vout_slp [`PCG_RAILS];
  logic [`PCG_IRQ_BITS-1:0] irq_stat;
  logic [`PCG_IRQ_BITS-1:0] irq_mask;

  // pin edges
  logic      in1_q;
  logic      in2_q;
  pcg_rail_t pg_q;
  wire in1_s    = pin_s[0];
  wire in2_s    = pin_s[1];
  wire in1_rise = in1_s & ~in1_q;
  wire in1_fall = ~in1_s & in1_q;
  wire in2_rise = in2_s & ~in2_q & ~sleep_mode;
  wire in2_fall = ~in2_s & in2_q & ~sleep_mode;

  // rail enable and sleep
  wire pcg_rail_t en_set      = (in1_rise ? grp1 : 8'h00) | (in2_rise ? grp2 : 8'h00);
  wire pcg_rail_t en_clr      = (in1_fall ? grp1 : 8'h00) | (in2_fall ? grp2 : 8'h00);
  wire pcg_rail_t next_enable = (o_rail_enable & ~en_clr) | en_set;
  wire pcg_rail_t next_sleep  = (sleep_mode & ~in2_s) ? slp_grp : 8'h00;
  logic [63:0] next_vout;

  always_comb begin
    next_vout = '0;
    for (int r = 0; r < `PCG_RAILS; r++) begin
      next_vout[r*8 +: 8] = next_sleep[r] ? vout_slp[r] : vout_nrm[r];
    end
  end

  // interrupt events; a set in the same cycle as a clear wins
  wire [`PCG_IRQ_BITS-1:0] irq_ev = {
    |(next_sleep & ~o_rail_sleep),
    |(pg_q & ~pg_s & o_rail_enable),
    in2_s ^ in2_q,
    in1_s ^ in1_q
  };

  // write channel
  logic       aw_hold;
  logic       w_hold;
  logic [7:0] aw_addr;
  logic       aw_high;
  logic [7:0] w_data;
  logic       w_be0;
  wire  wr_go   = aw_hold & w_hold & ~o_bvalid;
  wire  wr_b0   = wr_go & w_be0 & ~aw_high;
  wire  wa_vout = (aw_addr[7:6] == `PCG_VOUT_REGION) & (aw_addr[1:0] == 2'h0);
  wire  wa_pgs  = (aw_addr[7:4] == 4'h1 & aw_addr[3]) | (aw_addr[7:3] == 5'h04);
  wire [1:0] pgs_idx = 2'(aw_addr[7:2] - 6'h06);
  wire  we_grp1 = wr_b0 & pcg_hit(aw_addr, `PCG_OFF_GRP1);
  wire  we_grp2 = wr_b0 & pcg_hit(aw_addr, `PCG_OFF_GRP2);
  wire  we_slpg = wr_b0 & pcg_hit(aw_addr, `PCG_OFF_SLP_GRP);
  wire  we_ctrl = wr_b0 & pcg_hit(aw_addr, `PCG_OFF_CTRL);
  wire  we_cfg  = wr_b0 & pcg_hit(aw_addr, `PCG_OFF_GPO_CFG);
  wire  we_val  = wr_b0 & pcg_hit(aw_addr, `PCG_OFF_GPO_VAL);
  wire  we_pgs  = wr_b0 & wa_pgs & (aw_addr[1:0] == 2'h0);
  wire  we_ist  = wr_b0 & pcg_hit(aw_addr, `PCG_OFF_IRQ_STAT);
  wire  we_imk  = wr_b0 & pcg_hit(aw_addr, `PCG_OFF_IRQ_MASK);
  wire  we_vout = wr_b0 & wa_vout;
  wire  w_known = ~aw_high & (wa_vout | (aw_addr[1:0] == 2'h0 & aw_addr <= 8'h30));

  assign o_awready = ~aw_hold & ~o_bvalid;
  assign o_wready  = ~w_hold & ~o_bvalid;
  assign o_arready = ~o_rvalid;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      aw_hold  <= 1'b0;
      w_hold   <= 1'b0;
      aw_addr  <= 8'h00;
      aw_high  <= 1'b0;
      w_data   <= 8'h00;
      w_be0    <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp  <= `PCG_RESP_OKAY;
    end else begin
      if (i_awvalid & o_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= i_awaddr[7:0];
        aw_high <= |i_awaddr[31:8];
      end else if (wr_go) begin
        aw_hold <= 1'b0;
      end
      if (i_wvalid & o_wready) begin
        w_hold <= 1'b1;
        w_data <= i_wdata[7:0];
        w_be0  <= i_wstrb[0];
      end else if (wr_go) begin
        w_hold <= 1'b0;
      end
      if (wr_go) begin
        o_bvalid <= 1'b1;
        o_bresp  <= w_known ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
      end else if (i_bready) begin
        o_bvalid <= 1'b0;
      end
    end
  end

  // registers
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      grp1       <= `PCG_GRP1_RST;
      grp2       <= `PCG_GRP2_RST;
      slp_grp    <= `PCG_SLP_GRP_RST;
      sleep_mode <= 1'b0;
      gpo_src    <= 4'h0;
      gpo_od     <= 3'h0;
      gpo_val    <= 4'h0;
      irq_mask   <= 4'h0;
      for (int k = 0; k < `PCG_GPOS; k++) pg_sel[k] <= `PCG_PG_SEL_RST;
      for (int r = 0; r < `PCG_RAILS; r++) begin
        vout_nrm[r] <= `PCG_VOUT_NRM_RST;
        vout_slp[r] <= `PCG_VOUT_SLP_RST;
      end
    end else begin
      if (we_grp1) grp1 <= w_data;
      if (we_grp2) grp2 <= w_data;
      if (we_slpg) slp_grp <= w_data;
      if (we_ctrl) sleep_mode <= w_data[`PCG_CTRL_SLEEP_BIT];
      if (we_cfg) begin
        gpo_src <= w_data[3:0];
        gpo_od  <= w_data[`PCG_CFG_OD_LSB +: 3];
      end
      if (we_val) gpo_val <= w_data[3:0];
      if (we_imk) irq_mask <= w_data[3:0];
      if (we_pgs) pg_sel[pgs_idx] <= w_data;
      if (we_vout & ~aw_addr[5]) vout_nrm[aw_addr[4:2]] <= w_data;
      if (we_vout & aw_addr[5]) vout_slp[aw_addr[4:2]] <= w_data;
    end
  end

  // rail state, edge history and interrupt
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      in1_q                <= 1'b0;
      in2_q                <= 1'b0;
      pg_q                 <= 8'h00;
      o_rail_enable        <= 8'h00;
      o_rail_sleep         <= 8'h00;
      o_rail_vout_code     <= '0;
      irq_stat             <= 4'h0;
      o_interrupt_out_n_oe <= 1'b0;
    end else begin
      in1_q                <= in1_s;
      in2_q                <= in2_s;
      pg_q                 <= pg_s;
      o_rail_enable        <= next_enable;
      o_rail_sleep         <= next_sleep;
      o_rail_vout_code     <= next_vout;
      irq_stat             <= (irq_stat & ~(we_ist ? w_data[3:0] : 4'h0)) | irq_ev;
      o_interrupt_out_n_oe <= |(irq_stat & irq_mask);
    end
  end

  // pin never drives high; the pull-up gives the idle level
  assign o_interrupt_out_n_o = 1'b0;

  // read channel
  wire [7:0] ra      = i_araddr[7:0];
  wire       ra_vout = (ra[7:6] == `PCG_VOUT_REGION) & (ra[1:0] == 2'h0) & ~|i_araddr[31:8];
  wire       ra_reg  = (ra[1:0] == 2'h0) & (ra <= 8'h30) & ~|i_araddr[31:8];
  wire [1:0] rpg_idx = 2'(ra[7:2] - 6'h06);
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    if (ra_vout) begin
      rd_mux[7:0] = ra[5] ? vout_slp[ra[4:2]] : vout_nrm[ra[4:2]];
    end else if (ra_reg) begin
      unique case (ra)
        `PCG_OFF_GRP1:     rd_mux[7:0] = grp1;
        `PCG_OFF_GRP2:     rd_mux[7:0] = grp2;
        `PCG_OFF_SLP_GRP:  rd_mux[7:0] = slp_grp;
        `PCG_OFF_CTRL:     rd_mux[0] = sleep_mode;
        `PCG_OFF_GPO_CFG:  rd_mux[6:0] = {gpo_od, gpo_src};
        `PCG_OFF_GPO_VAL:  rd_mux[3:0] = gpo_val;
        `PCG_OFF_STATUS:   rd_mux[25:0] = {in2_s, in1_s, pg_s, o_rail_sleep, o_rail_enable};
        `PCG_OFF_IRQ_STAT: rd_mux[3:0] = irq_stat;
        `PCG_OFF_IRQ_MASK: rd_mux[3:0] = irq_mask;
        default:           rd_mux[7:0] = pg_sel[rpg_idx];
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_rvalid <= 1'b0;
      o_rdata  <= 32'h0;
      o_rresp  <= `PCG_RESP_OKAY;
    end else if (i_arvalid & o_arready) begin
      o_rvalid <= 1'b1;
      o_rdata  <= rd_mux;
      o_rresp  <= (ra_vout | ra_reg) ? `PCG_RESP_OKAY : `PCG_RESP_SLVERR;
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
    end
  end

  // general outputs; the fourth is held open-drain
  logic [3:0] gpo_o;
  logic [3:0] gpo_oe;
  wire  [3:0] gpo_od_all = {1'b1, gpo_od};

  for (genvar k = 0; k < `PCG_GPOS; k++) begin : g_gpo
    pcg_gpo_drive u_drv (
      .i_clk        (i_clk),
      .i_rstn       (i_rstn),
      .i_src        (pcg_gpo_src_e'(gpo_src[k])),
      .i_reg_val    (gpo_val[k]),
      .i_sel        (pg_sel[k]),
      .i_open_drain (gpo_od_all[k]),
      .i_pgood      (pg_s),
      .o_pin_o      (gpo_o[k]),
      .o_pin_oe     (gpo_oe[k])
    );
  end

  assign o_general_out_1_o            = gpo_o[0];
  assign o_general_out_1_oe           = gpo_oe[0];
  assign o_general_out_2_o            = gpo_o[1];
  assign o_general_out_2_oe           = gpo_oe[1];
  assign o_general_out_3_o            = gpo_o[2];
  assign o_general_out_3_oe           = gpo_oe[2];
  assign o_general_out_4_opendrain_o  = gpo_o[3];
  assign o_general_out_4_opendrain_oe = gpo_oe[3];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  en_rise_a: assert property (
    in1_rise |=> ((o_rail_enable & $past(grp1)) == $past(grp1)))
    else $error("group 1 not enabled after input rose");

  en_fall_a: assert property (
    (in1_fall && !in2_rise) |=> ((o_rail_enable & $past(grp1)) == 8'h00))
    else $error("group 1 not disabled after input fell");

  sleep_noen_a: assert property (
    (sleep_mode && !in1_rise && !in1_fall) |=> $stable(o_rail_enable))
    else $error("sleep request input changed rail enables");

  sleep_enter_a: assert property (
    (sleep_mode && !in2_s) |=> (o_rail_sleep == $past(slp_grp)))
    else $error("sleep group not in sleep");

  sleep_exit_a: assert property (
    !(sleep_mode && !in2_s) |=> (o_rail_sleep == 8'h00))
    else $error("rails asleep without sleep request");

  vout_sel_a: assert property (
    o_rail_sleep[1] |-> (o_rail_vout_code[15:8] == $past(vout_slp[1])))
    else $error("sleeping rail not using sleep voltage");

  irq_pin_a: assert property (
    (|(irq_stat & irq_mask)) |=> (o_interrupt_out_n_oe && !o_interrupt_out_n_o))
    else $error("pending interrupt not driven low");

  general_out_4_opendrain_od_a: assert property (
    !o_general_out_4_opendrain_o)
    else $error("output 4 drove high");

  gpo_reg_a: assert property (
    (gpo_src[0] && !gpo_od[0]) |=> (o_general_out_1_o == $past(gpo_val[0])))
    else $error("output 1 does not follow its register bit");

  gpo_pg_a: assert property (
    (!gpo_src[1] && gpo_od[1]) |=>
      (o_general_out_2_oe == !$past(pcg_group_good(pg_s, pg_sel[1]))))
    else $error("output 2 does not show group power-good");

endmodule

/* File: pcg_host_model.sv */
`timescale 1ns/1ps
module pcg_host_model
  import pcg_pkg::*;
(
  // clock
  input  wire logic       i_clk,
  // pins toward the device
  output logic            o_pin1,
  output logic            o_pin2,
  output pcg_rail_t       o_pgood,
  // open-drain and push-pull outputs of the device
  input  wire logic       i_irq_o,
  input  wire logic       i_irq_oe,
  input  wire logic [3:0] i_gpo_o,
  input  wire logic [3:0] i_gpo_oe,
  // resolved board levels
  output logic            o_irq_wire_n,
  output logic [3:0]      o_gpo_wire
);
  initial begin
    o_pin1  = 1'b0;
    o_pin2  = 1'b0;
    o_pgood = 8'hff;
  end

  // board pull-ups give the high level whenever nothing drives the line
  assign o_irq_wire_n = i_irq_oe ? i_irq_o : 1'b1;
  assign o_gpo_wire   = (i_gpo_oe & i_gpo_o) | ~i_gpo_oe;

  task automatic set_pins(input logic p1, input logic p2);
    @(posedge i_clk);
    o_pin1 <= p1;
    o_pin2 <= p2;
  endtask

  task automatic set_pgood(input pcg_rail_t v);
    @(posedge i_clk);
    o_pgood <= v;
  endtask
endmodule

/* File: pcg_top_tb.sv */
`timescale 1ns/1ps
`include "pcg_defs.svh"
module pcg_top_tb
  import pcg_pkg::*;
;
  logic i_clk = 1'b0, i_rstn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0, gpo_o, gpo_oe, gpo_wire;
  logic awready, wready, bvalid, arready, rvalid, pin1, pin2, irq_o, irq_oe, irq_wire_n;
  logic [1:0] bresp, rresp;
  pcg_rail_t pgood, rail_en, rail_slp;
  logic [63:0] vout;
  int fails = 0, check_count = 0;
  // write strobe offered by the bus master; byte 0 off means nothing lands
  logic [3:0] strb_use = 4'hf;

  always #12.5 i_clk = ~i_clk;

  pcg_top u_dut (
    .i_clk(i_clk), .i_rstn(i_rstn),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
    .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
    .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_rail_group_enable_in_1(pin1), .i_enable_or_sleep_request_in_2(pin2),
    .i_rail_pgood(pgood), .o_rail_enable(rail_en), .o_rail_sleep(rail_slp),
    .o_rail_vout_code(vout),
    .o_interrupt_out_n_o(irq_o), .o_interrupt_out_n_oe(irq_oe),
    .o_general_out_1_o(gpo_o[0]), .o_general_out_1_oe(gpo_oe[0]),
    .o_general_out_2_o(gpo_o[1]), .o_general_out_2_oe(gpo_oe[1]),
    .o_general_out_3_o(gpo_o[2]), .o_general_out_3_oe(gpo_oe[2]),
    .o_general_out_4_opendrain_o(gpo_o[3]), .o_general_out_4_opendrain_oe(gpo_oe[3])
  );

  pcg_host_model u_host (
    .i_clk(i_clk), .o_pin1(pin1), .o_pin2(pin2), .o_pgood(pgood),
    .i_irq_o(irq_o), .i_irq_oe(irq_oe), .i_gpo_o(gpo_o), .i_gpo_oe(gpo_oe),
    .o_irq_wire_n(irq_wire_n), .o_gpo_wire(gpo_wire)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    awvalid <= 1'b1;
    awaddr  <= {24'h0, a};
    wvalid  <= 1'b1;
    wdata   <= d;
    wstrb   <= strb_use;
    bready  <= 1'b1;
    // wait for each channel separately; the slave may take them apart
    while (n < 50) begin
      @(posedge i_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        check(32'(bresp), 32'(r));
        bready <= 1'b0;
        n = 100;
      end
    end
    if (n < 100) fails++;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    arvalid <= 1'b1;
    araddr  <= {24'h0, a};
    rready  <= 1'b1;
    while (n < 50) begin
      @(posedge i_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        check(rdata, d);
        check(32'(rresp), 32'(r));
        rready <= 1'b0;
        n = 100;
      end
    end
    if (n < 100) fails++;
  endtask

  task automatic pins(input logic p1, input logic p2);
    u_host.set_pins(p1, p2);
    // synchroniser plus one register stage, with margin
    repeat (8) @(posedge i_clk);
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    final_report();
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    rd(`PCG_OFF_GRP1, 32'h0, `PCG_RESP_OKAY);
    rd(8'h44, 32'h40, `PCG_RESP_OKAY);
    rd(8'h64, 32'h30, `PCG_RESP_OKAY);
    rd(8'h34, 32'h0, `PCG_RESP_SLVERR);
    wr(8'h38, 32'h1, `PCG_RESP_SLVERR);
    wr(`PCG_OFF_GRP1, 32'h05, `PCG_RESP_OKAY);
    wr(`PCG_OFF_GRP2, 32'h0a, `PCG_RESP_OKAY);
    wr(`PCG_OFF_IRQ_MASK, 32'h01, `PCG_RESP_OKAY);
    check(32'(irq_wire_n), 32'h1);
    pins(1'b1, 1'b0);
    check(32'(rail_en), 32'h05);
    check(32'({irq_oe, irq_o, irq_wire_n}), 32'h4);
    wr(`PCG_OFF_IRQ_STAT, 32'h0f, `PCG_RESP_OKAY);
    repeat (3) @(posedge i_clk);
    check(32'({irq_oe, irq_wire_n}), 32'h1);
    pins(1'b1, 1'b1);
    check(32'(rail_en), 32'h0f);
    pins(1'b0, 1'b1);
    check(32'(rail_en), 32'h0a);
    // masked event stays off the pin but is still recorded
    wr(`PCG_OFF_IRQ_MASK, 32'h0, `PCG_RESP_OKAY);
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b1);
    check(32'(irq_wire_n), 32'h1);
    // both pins changed since the clear, so both change bits are pending
    rd(`PCG_OFF_IRQ_STAT, 32'h3, `PCG_RESP_OKAY);
    wr(`PCG_OFF_CTRL, 32'h1, `PCG_RESP_OKAY);
    wr(`PCG_OFF_SLP_GRP, 32'h02, `PCG_RESP_OKAY);
    pins(1'b0, 1'b0);
    check(32'(rail_slp), 32'h02);
    check(32'(rail_en), 32'h0a);
    check(32'(vout[15:0]), 32'h3040);
    rd(`PCG_OFF_STATUS, 32'h00ff020a, `PCG_RESP_OKAY);
    pins(1'b0, 1'b1);
    check(32'(rail_slp), 32'h0);
    check(32'(rail_en), 32'h0a);
    check(32'(vout[15:8]), 32'h40);
    for (int od = 0; od < 2; od++) begin
      for (int v = 0; v < 2; v++) begin
        wr(`PCG_OFF_GPO_CFG, od ? 32'h7f : 32'h0f, `PCG_RESP_OKAY);
        wr(`PCG_OFF_GPO_VAL, v ? 32'hf : 32'h0, `PCG_RESP_OKAY);
        repeat (3) @(posedge i_clk);
        for (int n = 0; n < 4; n++) begin
          if (od == 0 && n < 3) check(32'({gpo_oe[n], gpo_o[n]}), v ? 32'h3 : 32'h2);
          else check(32'({gpo_oe[n], gpo_o[n]}), v ? 32'h0 : 32'h2);
          check(32'(gpo_wire[n]), 32'(v));
        end
      end
    end
    wr(`PCG_OFF_GPO_CFG, 32'h0, `PCG_RESP_OKAY);
    wr(`PCG_OFF_PG_SEL0, 32'h03, `PCG_RESP_OKAY);
    wr(8'h24, 32'h04, `PCG_RESP_OKAY);
    u_host.set_pgood(8'h01);
    repeat (8) @(posedge i_clk);
    check(32'(gpo_wire), 32'h6);
    u_host.set_pgood(8'h07);
    repeat (8) @(posedge i_clk);
    check(32'(gpo_wire), 32'hf);
    // open-drain on outputs 1-3 with power-good as the source
    wr(`PCG_OFF_GPO_CFG, 32'h70, `PCG_RESP_OKAY);
    wr(8'h1c, 32'h02, `PCG_RESP_OKAY);
    repeat (3) @(posedge i_clk);
    check(32'({gpo_oe, gpo_wire}), 32'h0f);
    u_host.set_pgood(8'h01);
    repeat (8) @(posedge i_clk);
    check(32'({gpo_oe, gpo_wire}), 32'hb4);
    strb_use = 4'he;
    wr(`PCG_OFF_GRP1, 32'hff, `PCG_RESP_OKAY);
    strb_use = 4'hf;
    rd(`PCG_OFF_GRP1, 32'h05, `PCG_RESP_OKAY);
    final_report();
  end
endmodule
